/* rtl/sdram_bls_pkg.sv */
// Purpose: Shared constants for the burst and latency select block.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Field positions index the configuration and status words.
package sdram_bls_pkg;
   localparam int         ADDR_W         = 8;
   localparam int         LAT_W          = 5;
   localparam int         SUM_W          = 7;
   localparam int         CAL_W          = 3;
   localparam int         PL_W           = 3;
   localparam logic [7:0] OFF_CONFIG     = 8'h00;
   localparam logic [7:0] OFF_STATUS     = 8'h04;
   localparam int         CFG_BURST_LSB  = 0;
   localparam int         CFG_PARITY_BIT = 2;
   localparam int         CFG_DLL_BIT    = 3;
   localparam int         CFG_CL_LSB     = 4;
   localparam int         CFG_CWL_LSB    = 9;
   localparam int         CFG_AL_LSB     = 14;
   localparam int         CFG_CAL_LSB    = 19;
   localparam int         CFG_PL_LSB     = 22;
   localparam int         STS_BUSY       = 0;
   localparam int         STS_CHOP       = 1;
   localparam int         STS_DLL        = 2;
   localparam int         STS_REFUSED    = 3;
   localparam int         STS_OVERFLOW   = 4;
   localparam int         STS_LAT_LSB    = 8;
   localparam logic [1:0] RST_BURST      = 2'h0;
   localparam logic [4:0] RST_CL         = 5'h0B;
   localparam logic [4:0] RST_CWL        = 5'h09;
   localparam logic [4:0] RST_AL         = 5'h00;
   localparam logic [2:0] RST_PL         = 3'h4;
   localparam logic [2:0] RST_CAL        = 3'h0;
   localparam logic [1:0] BURST_FIXED8   = 2'h0;
   localparam logic [1:0] BURST_OTF      = 2'h1;
   localparam logic [1:0] BURST_FIXED4   = 2'h2;
   localparam logic [1:0] CMD_READ       = 2'h1;
   localparam logic [1:0] CMD_WRITE      = 2'h2;
   localparam logic [3:0] BEATS_EIGHT    = 4'h8;
   localparam logic [3:0] BEATS_FOUR     = 4'h4;
   typedef enum {PH_IDLE, PH_WAIT, PH_BURST} phase_t;
endpackage

/* rtl/wdata_fifo.sv */
// Purpose: Write data buffer with valid and ready on both sides.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Full and empty are registered flags.
`timescale 1ns/1ns
module wdata_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_data,
   input  wire logic             i_valid,
   output logic                  o_ready,
   output logic [WIDTH-1:0]      o_data,
   output logic                  o_valid,
   input  wire logic             i_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign push    = i_valid & o_ready;
   assign pop     = o_valid & i_ready;
   assign o_data  = mem[rd_ptr];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr  <= '0;
         rd_ptr  <= '0;
         count   <= '0;
         o_ready <= 1'b1;
         o_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count   <= count + 1'b1;
            o_ready <= (count != (AW+1)'(DEPTH - 1));
            o_valid <= 1'b1;
         end else if (pop && !push) begin
            count   <= count - 1'b1;
            o_ready <= 1'b1;
            o_valid <= (count != (AW+1)'(1));
         end
      end
   end
endmodule

/* rtl/sdram_burst_latency_select.sv */
// Purpose: Decode column commands into burst length and read or write latency.
// Assumes: Link pins are asynchronous to I_MCLK and are synchronised here.
// Notes:   One column command is tracked at a time; others that arrive while busy are dropped.
`timescale 1ns/1ns
// Behaviour
// R1: Read latency adds parity latency when enabled.
// R2: Write latency adds parity latency when enabled.
// R3: Eight beats for field 00, or 01 with select high.
// R4: Field 01 with select low chops to four.
// R5: Field 10 chops every command to four.
// R6: Termination timing ignores command latency mode.
// R7: Writes only honoured with DLL enabled and locked.
// R8: Controller trains input capture or uses worst window.
// R9: With command latency, sample command after programmed clocks.
module sdram_burst_latency_select #(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic        I_MCLK,
   input  wire logic        I_RST,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [31:0] I_PWDATA,
   output logic [31:0]      O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire logic        I_LINK_CK,
   input  wire logic        I_CS_N,
   input  wire logic [1:0]  I_CMD,
   input  wire logic        I_BURST_CHOP_SELECT_BIT,
   input  wire logic        I_ON_DIE_TERMINATION,
   input  wire logic        I_DQS,
   input  wire logic [7:0]  I_DQ,
   input  wire logic        I_DLL_LOCKED,
   output logic             O_ON_DIE_TERMINATION,
   output logic             O_RD_ACTIVE,
   output logic             O_RD_CHOP,
   output logic [7:0]       O_WDATA,
   output logic             O_WDATA_VALID,
   input  wire logic        I_WDATA_READY,
   output logic             O_WBUF_READY
);
   // ------------------------------------------------------------------
   // Pin synchronisers and link clock edge detection
   // ------------------------------------------------------------------
   logic [16:0] sync1;
   logic [16:0] sync2;
   logic        ck_d;
   logic        dqs_d;
   logic        ck_rise;
   logic        dqs_edge;
   logic        s_ck;
   logic        s_cs_n;
   logic [1:0]  s_cmd;
   logic        s_bcs;
   logic        s_odt;
   logic        s_dqs;
   logic        s_dll;
   logic [7:0]  s_dq;

   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         sync1 <= 17'h00002;
         sync2 <= 17'h00002;
         ck_d  <= 1'b0;
         dqs_d <= 1'b0;
      end else begin
         sync1 <= {I_LINK_CK, I_CMD, I_BURST_CHOP_SELECT_BIT, I_ON_DIE_TERMINATION,
                   I_DQS, I_DLL_LOCKED, I_DQ, I_CS_N, 1'b0};
         sync2 <= sync1;
         ck_d  <= s_ck;
         dqs_d <= s_dqs;
      end
   end

   assign {s_ck, s_cmd, s_bcs, s_odt, s_dqs, s_dll, s_dq, s_cs_n} = sync2[16:1];
   assign ck_rise  = s_ck & ~ck_d;
   assign dqs_edge = s_dqs ^ dqs_d;

   // ------------------------------------------------------------------
   // Configuration register
   // ------------------------------------------------------------------
   logic [1:0]  cfg_burst;
   logic        cfg_parity;
   logic        cfg_dll;
   logic [4:0]  cfg_cl;
   logic [4:0]  cfg_cwl;
   logic [4:0]  cfg_al;
   logic [2:0]  cfg_cal;
   logic [2:0]  cfg_pl;
   logic        apb_access;
   logic        apb_write;
   logic        addr_ok;
   logic        refused;
   logic        overflow;
   logic [31:0] status_word;
   logic [31:0] config_word;

   assign apb_access = I_PSEL & I_PENABLE & ~O_PREADY;
   assign apb_write  = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
   assign addr_ok    = (I_PADDR == sdram_bls_pkg::OFF_CONFIG) |
                       (I_PADDR == sdram_bls_pkg::OFF_STATUS);

   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         cfg_burst  <= sdram_bls_pkg::RST_BURST;
         cfg_parity <= 1'b0;
         cfg_dll    <= 1'b0;
         cfg_cl     <= sdram_bls_pkg::RST_CL;
         cfg_cwl    <= sdram_bls_pkg::RST_CWL;
         cfg_al     <= sdram_bls_pkg::RST_AL;
         cfg_cal    <= sdram_bls_pkg::RST_CAL;
         cfg_pl     <= sdram_bls_pkg::RST_PL;
      end else if (apb_write && I_PADDR == sdram_bls_pkg::OFF_CONFIG) begin
         cfg_burst  <= I_PWDATA[sdram_bls_pkg::CFG_BURST_LSB +: 2];
         cfg_parity <= I_PWDATA[sdram_bls_pkg::CFG_PARITY_BIT];
         cfg_dll    <= I_PWDATA[sdram_bls_pkg::CFG_DLL_BIT];
         cfg_cl     <= I_PWDATA[sdram_bls_pkg::CFG_CL_LSB +: 5];
         cfg_cwl    <= I_PWDATA[sdram_bls_pkg::CFG_CWL_LSB +: 5];
         cfg_al     <= I_PWDATA[sdram_bls_pkg::CFG_AL_LSB +: 5];
         cfg_cal    <= I_PWDATA[sdram_bls_pkg::CFG_CAL_LSB +: 3];
         cfg_pl     <= I_PWDATA[sdram_bls_pkg::CFG_PL_LSB +: 3];
      end
   end

   // ------------------------------------------------------------------
   // APB answer: ready one cycle into the access phase
   // ------------------------------------------------------------------
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA  <= 32'h00000000;
      end else begin
         O_PREADY  <= apb_access;
         O_PSLVERR <= apb_access & ~addr_ok;
         if (apb_access && !I_PWRITE && I_PADDR == sdram_bls_pkg::OFF_CONFIG) begin
            O_PRDATA <= config_word;
         end else if (apb_access && !I_PWRITE && I_PADDR == sdram_bls_pkg::OFF_STATUS) begin
            O_PRDATA <= status_word;
         end else begin
            O_PRDATA <= 32'h00000000;
         end
      end
   end

   assign config_word = {7'h00, cfg_pl, cfg_cal, cfg_al, cfg_cwl, cfg_cl,
                         cfg_dll, cfg_parity, cfg_burst};

   // ------------------------------------------------------------------
   // Command sampling, burst decode and latency selection
   // ------------------------------------------------------------------
   sdram_bls_pkg::phase_t phase;
   logic [2:0]  cal_cnt;
   logic        cmd_sample;
   logic        cmd_rw;
   logic        cmd_is_write;
   logic        cmd_take;
   logic        write_refuse;
   logic        next_chop;
   logic [6:0]  next_rd_lat;
   logic [6:0]  next_wr_lat;
   logic [6:0]  lat_cnt;
   logic [6:0]  last_lat;
   logic [3:0]  beats;
   logic [3:0]  burst_cnt;
   logic [3:0]  beat_cnt;
   logic        is_write;
   logic        chop;
   logic [2:0]  added_pl;

   // With command latency the command is taken cfg_cal link clocks after the select edge.
   assign cmd_sample = ck_rise & ((cfg_cal == 3'h0) ? ~s_cs_n : (cal_cnt == 3'h1)); // R9
   assign cmd_rw       = cmd_sample & ((s_cmd == sdram_bls_pkg::CMD_READ) |
                                       (s_cmd == sdram_bls_pkg::CMD_WRITE));
   assign cmd_is_write = (s_cmd == sdram_bls_pkg::CMD_WRITE);
   assign write_refuse = cmd_rw & cmd_is_write & ~(cfg_dll & s_dll); // R7
   assign cmd_take     = cmd_rw & ~write_refuse & (phase == sdram_bls_pkg::PH_IDLE);

   assign next_chop = (cfg_burst == sdram_bls_pkg::BURST_FIXED4) | // R5
                      ((cfg_burst == sdram_bls_pkg::BURST_OTF) & ~s_bcs); // R3 R4
   assign added_pl    = cfg_parity ? cfg_pl : 3'h0;
   assign next_rd_lat = 7'(cfg_cl) + 7'(cfg_al) + 7'(added_pl); // R1
   assign next_wr_lat = 7'(cfg_cwl) + 7'(cfg_al) + 7'(added_pl); // R2

   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         cal_cnt <= 3'h0;
      end else if (ck_rise && cal_cnt != 3'h0) begin
         cal_cnt <= cal_cnt - 3'h1;
      end else if (ck_rise && cfg_cal != 3'h0 && !s_cs_n) begin
         cal_cnt <= cfg_cal; // R9
      end
   end

   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         phase     <= sdram_bls_pkg::PH_IDLE;
         lat_cnt   <= 7'h00;
         last_lat  <= 7'h00;
         beats     <= sdram_bls_pkg::BEATS_EIGHT;
         burst_cnt <= 4'h0;
         is_write  <= 1'b0;
         chop      <= 1'b0;
      end else begin
         case (phase)
            sdram_bls_pkg::PH_IDLE: begin
               if (cmd_take) begin
                  is_write <= cmd_is_write;
                  chop     <= next_chop;
                  beats    <= next_chop ? sdram_bls_pkg::BEATS_FOUR
                                        : sdram_bls_pkg::BEATS_EIGHT; // R3 R4 R5
                  lat_cnt  <= cmd_is_write ? next_wr_lat : next_rd_lat; // R1 R2
                  last_lat <= cmd_is_write ? next_wr_lat : next_rd_lat;
                  phase    <= sdram_bls_pkg::PH_WAIT;
               end
            end
            sdram_bls_pkg::PH_WAIT: begin
               if (ck_rise) begin
                  if (lat_cnt <= 7'h01) begin
                     burst_cnt <= {1'b0, beats[3:1]};
                     phase     <= sdram_bls_pkg::PH_BURST;
                  end else begin
                     lat_cnt <= lat_cnt - 7'h01;
                  end
               end
            end
            sdram_bls_pkg::PH_BURST: begin
               if (ck_rise) begin
                  if (burst_cnt <= 4'h1) begin
                     phase <= sdram_bls_pkg::PH_IDLE;
                  end
                  burst_cnt <= burst_cnt - 4'h1;
               end
            end
            default: begin
               phase <= sdram_bls_pkg::PH_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Termination follows the pin directly, whatever the command latency
   // ------------------------------------------------------------------
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_ON_DIE_TERMINATION <= 1'b0;
      end else if (ck_rise) begin
         O_ON_DIE_TERMINATION <= s_odt; // R6
      end
   end

   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_RD_ACTIVE <= 1'b0;
         O_RD_CHOP   <= 1'b0;
      end else begin
         O_RD_ACTIVE <= (phase == sdram_bls_pkg::PH_BURST) & ~is_write;
         O_RD_CHOP   <= chop;
      end
   end

   // ------------------------------------------------------------------
   // Write data capture into the buffer
   // ------------------------------------------------------------------
   logic       push;
   logic       buf_ready;
   logic [7:0] buf_data;
   logic       buf_valid;
   logic       buf_pop_ready;

   assign push = dqs_edge & is_write & (phase == sdram_bls_pkg::PH_BURST) &
                 (beat_cnt < beats);

   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         beat_cnt <= 4'h0;
      end else if (cmd_take) begin
         beat_cnt <= 4'h0;
      end else if (push) begin
         beat_cnt <= beat_cnt + 4'h1;
      end
   end

   wdata_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_wbuf (
      .i_clk   (I_MCLK),
      .i_rst   (I_RST),
      .i_data  (s_dq),
      .i_valid (push),
      .o_ready (buf_ready),
      .o_data  (buf_data),
      .o_valid (buf_valid),
      .i_ready (buf_pop_ready)
   );

   assign buf_pop_ready = ~O_WDATA_VALID | I_WDATA_READY;

   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_WDATA       <= 8'h00;
         O_WDATA_VALID <= 1'b0;
         O_WBUF_READY  <= 1'b1;
      end else begin
         O_WBUF_READY <= buf_ready;
         if (buf_pop_ready) begin
            O_WDATA       <= buf_data;
            O_WDATA_VALID <= buf_valid;
         end
      end
   end

   // ------------------------------------------------------------------
   // Status: sticky flags, write one to clear, a new event wins
   // ------------------------------------------------------------------
   logic clr_hit;
   assign clr_hit = apb_write & (I_PADDR == sdram_bls_pkg::OFF_STATUS);

   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         refused  <= 1'b0;
         overflow <= 1'b0;
      end else begin
         if (write_refuse) begin
            refused <= 1'b1; // R7
         end else if (clr_hit && I_PWDATA[sdram_bls_pkg::STS_REFUSED]) begin
            refused <= 1'b0;
         end
         if (push && !buf_ready) begin
            overflow <= 1'b1;
         end else if (clr_hit && I_PWDATA[sdram_bls_pkg::STS_OVERFLOW]) begin
            overflow <= 1'b0;
         end
      end
   end

   assign status_word = {17'h00000, last_lat, 3'h0, overflow, refused, s_dll, chop,
                         (phase != sdram_bls_pkg::PH_IDLE)};

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   sequence take_read_s;
      cmd_take && !cmd_is_write;
   endsequence
   sequence take_write_s;
      cmd_take && cmd_is_write;
   endsequence

   a_read_parity_lat: assert property (@(posedge I_MCLK) disable iff (I_RST) // R1
      take_read_s and (cfg_parity && !$changed(cfg_pl)) |=>
         lat_cnt == 7'($past(cfg_cl)) + 7'($past(cfg_al)) + 7'($past(cfg_pl)))
      else $error("read latency missing parity term");
   a_write_parity_lat: assert property (@(posedge I_MCLK) disable iff (I_RST) // R2
      take_write_s and cfg_parity |=>
         last_lat == 7'($past(cfg_cwl)) + 7'($past(cfg_al)) + 7'($past(cfg_pl)))
      else $error("write latency missing parity term");
   a_eight_beat_burst: assert property (@(posedge I_MCLK) disable iff (I_RST) // R3
      cmd_take && (cfg_burst == sdram_bls_pkg::BURST_FIXED8 ||
                   (cfg_burst == sdram_bls_pkg::BURST_OTF && s_bcs)) |=>
         beats == sdram_bls_pkg::BEATS_EIGHT && !chop)
      else $error("eight beat burst not chosen");
   a_otf_chop_four: assert property (@(posedge I_MCLK) disable iff (I_RST) // R4
      take_write_s and (cfg_burst == sdram_bls_pkg::BURST_OTF && !s_bcs) |=>
         beats == sdram_bls_pkg::BEATS_FOUR ##1 chop)
      else $error("on the fly chop not applied");
   a_fixed_chop_four: assert property (@(posedge I_MCLK) disable iff (I_RST) // R5
      cmd_take && cfg_burst == sdram_bls_pkg::BURST_FIXED4 |=> chop && beats == 4'h4)
      else $error("fixed chop not applied");
   a_odt_no_delay: assert property (@(posedge I_MCLK) disable iff (I_RST) // R6
      ck_rise |=> O_ON_DIE_TERMINATION == $past(s_odt))
      else $error("termination delayed");
   a_write_dll_gate: assert property (@(posedge I_MCLK) disable iff (I_RST) // R7
      cmd_rw && cmd_is_write && !(cfg_dll && s_dll) |=> refused && $stable(last_lat))
      else $error("write honoured without locked dll");
   a_cal_sample_point: assert property (@(posedge I_MCLK) disable iff (I_RST) // R9
      ck_rise && cfg_cal != 3'h0 && cal_cnt != 3'h1 |-> !cmd_sample)
      else $error("command sampled off the latency point");
endmodule

/* bench/link_ctrl_model.sv */
// Purpose: Memory controller model that drives the link pins of the block.
// Assumes: The link clock runs only while a frame is being sent.
// Notes:   Released lines carry inverted data so stale values never match.
`timescale 1ns/1ns
module link_ctrl_model (
   output logic       o_link_ck,
   output logic       o_cs_n,
   output logic [1:0] o_cmd,
   output logic       o_sel,
   output logic       o_odt,
   output logic       o_dqs,
   output logic [7:0] o_dq
);
   int         edges = 0;
   int         cmd_edge = 0;
   int         wr_from = 1 << 30;
   int         idx = 0;
   int         nbytes = 0;
   logic [7:0] bytes [8];

   initial begin
      o_link_ck = 1'b0;
      o_cs_n = 1'b1;
      o_cmd = 2'h0;
      o_sel = 1'b0;
      o_odt = 1'b0;
      o_dqs = 1'b0;
      o_dq = 8'h00;
   end

   task automatic put(input int i, input logic [7:0] v);
      bytes[i] = v;
   endtask

   // Data settles 15 ns ahead of each strobe edge and holds at least 47 ns after it.
   task automatic strobe();
      #20;
      if (edges >= wr_from && idx < nbytes) begin
         o_dq = bytes[idx];
         #15;
         o_dqs = ~o_dqs;
         idx++;
      end else begin
         o_dq = ~o_dq;
         #15;
      end
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         #25;
         o_link_ck = 1'b1;
         edges++;
         strobe();
         #27;
         o_link_ck = 1'b0;
         strobe();
         #3;
      end
   endtask

   task automatic column(input logic [1:0] cmd, input logic sel, input logic on_die_termination,
                         input int cal, input int lat, input int nb, input int n);
      idx = 0;
      nbytes = nb;
      o_odt = on_die_termination;
      o_cs_n = 1'b0;
      o_sel = sel;
      o_cmd = (cal == 0) ? cmd : ~cmd;
      if (cal != 0) begin
         tick(cal);
         o_cs_n = 1'b1;
         o_cmd = cmd;
      end
      tick(1);
      cmd_edge = edges;
      wr_from = (cmd == sdram_bls_pkg::CMD_WRITE) ? edges + lat : 1 << 30;
      o_cs_n = 1'b1;
      o_cmd = ~cmd;
      o_sel = ~sel;
      tick(n);
      wr_from = 1 << 30;
   endtask
endmodule

/* bench/test_sdram_burst_latency_select.sv */
// Purpose: Self-checking bench for the burst and latency select block.
// Assumes: The partner model drives the link; the APB master lives here.
// Notes:   Drivers queue expected results; monitors compare them.
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module test_sdram_burst_latency_select;
   typedef struct {int lat; int half; logic chop;} rd_t;
   typedef struct {logic [31:0] d; logic [31:0] m; logic err;} ap_t;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rnd = 32'hADBEFC69, cfg;
   logic dll_locked = 1'b1, wdata_ready = 1'b1, pready, pslverr, link_ck, cs_n, sel;
   logic on_die_termination, dqs, odt_out, rd_active, rd_chop, wdata_valid, wbuf_ready, ch, o;
   logic odt_prev = 1'b0, rd_prev = 1'b0;
   logic [1:0] cmd;
   logic [7:0] dq, wdata, b;
   int error_cnt = 0, n_compared = 0, i, lat, hb, e0;
   rd_t rq [$];
   ap_t aq [$];
   logic [7:0] wq [$];
   logic oq [$];
   rd_t r;
   ap_t a;
   logic [1:0] f_tab [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h1, 2'h1};
   logic s_tab [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   int c_tab [7] = '{0, 0, 0, 0, 0, 3, 4};

   sdram_burst_latency_select #(.FIFO_DEPTH(8)) i_dut (.I_MCLK(clk), .I_RST(rst),
      .I_PADDR(paddr), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .I_LINK_CK(link_ck), .I_CS_N(cs_n), .I_CMD(cmd), .I_BURST_CHOP_SELECT_BIT(sel),
      .I_ON_DIE_TERMINATION(on_die_termination), .I_DQS(dqs), .I_DQ(dq), .I_DLL_LOCKED(dll_locked),
      .O_ON_DIE_TERMINATION(odt_out), .O_RD_ACTIVE(rd_active), .O_RD_CHOP(rd_chop),
      .O_WDATA(wdata), .O_WDATA_VALID(wdata_valid), .I_WDATA_READY(wdata_ready),
      .O_WBUF_READY(wbuf_ready));
   link_ctrl_model i_ctrl (.o_link_ck(link_ck), .o_cs_n(cs_n), .o_cmd(cmd),
      .o_sel(sel), .o_odt(on_die_termination), .o_dqs(dqs), .o_dq(dq));

   always #5 clk = ~clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Reads pass the expected word in d and a mask in m.
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                      input logic [31:0] m);
      int k;
      k = 0;
      aq.push_back('{w ? 32'h0 : d, w ? 32'h0 : m, ad > 8'h04});
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1)
         error_cnt++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   always @(negedge clk) begin
      if (pready === 1'b1) begin
         a = aq.pop_front();
         `CHK(prdata & a.m, a.d & a.m)
         `CHK(pslverr, a.err)
      end
      if (rd_active === 1'b1 && !rd_prev) begin
         r = rq.pop_front();
         e0 = i_ctrl.edges;
         `CHK(e0 - i_ctrl.cmd_edge, r.lat)
         `CHK(rd_chop, r.chop)
      end
      if (rd_active === 1'b0 && rd_prev)
         `CHK(i_ctrl.edges - e0, r.half)
      rd_prev = rd_active === 1'b1;
      if (wdata_valid === 1'b1 && wdata_ready === 1'b1) begin
         b = wq.pop_front();
         `CHK(wdata, b)
      end
      if (odt_out !== odt_prev) begin
         o = oq.pop_front();
         `CHK(odt_out, o)
         odt_prev = odt_out;
      end
   end

   initial begin
      #200000;
      error_cnt++;
      conclude();
   end

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      apb(0, sdram_bls_pkg::OFF_CONFIG, 32'h010012B0, 32'hFFFFFFFF);
      apb(0, sdram_bls_pkg::OFF_STATUS, 32'h4, 32'h7F1F);
      apb(0, 8'h08, 32'h0, 32'hFFFFFFFF);
      apb(1, 8'h0C, 32'hFFFFFFFF, 32'h0);
      $display("test registers done");
      for (i = 0; i < 7; i++) begin
         rnd = lfsr(rnd);
         ch = f_tab[i] == 2'h2 || (f_tab[i] == 2'h1 && !s_tab[i]);
         hb = ch ? 2 : 4;
         lat = 11 + rnd[1:0] + (i % 2) * 4;
         cfg = {7'h00, 3'h4, 3'(c_tab[i]), 3'h0, rnd[1:0], 10'h12B, 1'b0, 1'(i % 2), f_tab[i]};
         apb(1, sdram_bls_pkg::OFF_CONFIG, cfg, 32'h0);
         apb(0, sdram_bls_pkg::OFF_CONFIG, cfg, 32'h01FFFFFF);
         rq.push_back('{lat, hb, ch});
         if (rnd[5] !== i_ctrl.o_odt)
            oq.push_back(rnd[5]);
         i_ctrl.column(sdram_bls_pkg::CMD_READ, s_tab[i], rnd[5], c_tab[i], 0, 0, lat + hb + 3);
         apb(0, sdram_bls_pkg::OFF_STATUS, {17'h0, 7'(lat), 6'h0, ch, 1'b0}, 32'h7F03);
      end
      $display("test reads done");
      cfg = {7'h00, 3'h4, 8'h00, 10'h12B, 4'h4};
      for (i = 0; i < 2; i++) begin
         apb(1, sdram_bls_pkg::OFF_CONFIG, cfg, 32'h0);
         i_ctrl.column(sdram_bls_pkg::CMD_WRITE, 1'b1, i_ctrl.o_odt, 0, 13, 0, 20);
         apb(0, sdram_bls_pkg::OFF_STATUS, 32'h8, 32'h8);
         apb(1, sdram_bls_pkg::OFF_STATUS, 32'h8, 32'h0);
         apb(0, sdram_bls_pkg::OFF_STATUS, 32'h0, 32'h8);
         cfg[3] = 1'b1;
         dll_locked <= i[0];
      end
      apb(1, sdram_bls_pkg::OFF_CONFIG, cfg, 32'h0);
      wdata_ready <= 1'b0;
      for (i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         wq.push_back(rnd[7:0]);
         i_ctrl.put(i % 8, rnd[7:0]);
         if (i == 7) begin
            i_ctrl.column(sdram_bls_pkg::CMD_WRITE, 1'b1, i_ctrl.o_odt, 0, 13, 8, 20);
            `CHK(wbuf_ready, 1'b1)
            apb(0, sdram_bls_pkg::OFF_STATUS, 32'h0D00, 32'h7F00);
            wdata_ready <= 1'b1;
            cfg[1:0] = sdram_bls_pkg::BURST_OTF;
            apb(1, sdram_bls_pkg::OFF_CONFIG, cfg, 32'h0);
         end
      end
      i_ctrl.column(sdram_bls_pkg::CMD_WRITE, 1'b0, i_ctrl.o_odt, 0, 13, 4, 20);
      apb(0, sdram_bls_pkg::OFF_STATUS, 32'h0D02, 32'h7F02);
      repeat (20) @(posedge clk);
      `CHK(wbuf_ready, 1'b1)
      `CHK(rq.size() + aq.size() + wq.size() + oq.size(), 0)
      $display("test writes done");
      conclude();
   end
endmodule
